// >>> common/bec_pkg.sv
`default_nettype none
package bec_pkg;
  // ------------------------------------------------------------
  // sequencer phases, as driven in by the mode sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    block_number_phase     = 3'b000,
    block_text_phase       = 3'b001,
    end_of_block_phase     = 3'b010,
    horizontal_check_phase = 3'b011,
    spiral_check_phase     = 3'b100,
    backup_phase           = 3'b101,
    delete_phase           = 3'b110,
    other_phase            = 3'b111
  } bec_phase_t;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFS_CTRL = 4'h0; // write: bit 0 clears state
  localparam logic [3:0] OFS_HLOC = 4'h4; // local horizontal check value
  localparam logic [3:0] OFS_SLOC = 4'h8; // local spiral check value
  localparam logic [3:0] OFS_STAT = 4'hc; // read-only status
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_HMIS_BIT = 1;
  localparam int STAT_SMIS_BIT = 2;
  localparam int STAT_UNITS_LSB = 8;
  localparam int STAT_TENS_LSB = 12;
  localparam int STAT_HREG_LSB = 16;
  localparam int STAT_SREG_LSB = 24;

  // ------------------------------------------------------------
  // counter and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] UNITS_LAST = 4'h9;   // units wrap after nine
  localparam logic [3:0] TENS_ARM = 4'h7;     // seventy
  localparam logic [3:0] TENS_FULL = 4'h8;    // eighty
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] CHK_RST = 8'h00;
  localparam logic ERR_RST = 1'b0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int BLK_PULSE_US = 10;
  localparam int BLK_PULSE_CYC_I = BLK_PULSE_US * CLK_MHZ;
  localparam logic [9:0] BLK_PULSE_CYC = 10'(BLK_PULSE_CYC_I);
endpackage
`default_nettype wire

// >>> design/bec_block_end_check.sv
// Functional notes
// - units wrap advances tens by one decade, up to eighty
// - tens holds between two units wraps
// - end gating armed at seventy, not backup
// - seventy to eighty gives ten microsecond pulse
// - block complete makes sequencer advance pulse
// - end phase advance without valid character errors
// - valid end character blocks advance error
// - error flag single bit, one means error
// - block number phase advance sets error
// - second delayed clock clears unless number high
// - check phase strobe gates eight data bits
// - horizontal phase ones set horizontal bits
// - horizontal zero bit routes delayed clock error
// - horizontal error only if number not low
// - horizontal phase keeps spiral register untouched
// - spiral phase loads second check character
// - spiral mismatch is OR of inverted bits
// - spiral mismatch with delayed clock sets error
// - incomplete block sets error flag
// - spiral advance goes number phase or backup
// - counter clears on text, delete, backup command
`timescale 1ns/1ps
`default_nettype none
module bec_block_end_check (
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [bec_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bec_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bec_pkg::DATA_W-1:0] reg_rdata_q,
  // sequencer and data path, same clock
  input wire bec_pkg::bec_phase_t phase,
  input wire logic char_pulse,
  input wire logic ext_adv,
  input wire logic eob_valid,
  input wire logic bn_high,
  input wire logic bn_low_seen,
  input wire logic dly_sample1,
  input wire logic dly_clk2,
  input wire logic [7:0] data_bits,
  input wire logic incomplete_blk,
  input wire logic backup_cmd,
  // results
  output logic seq_adv_q,
  output logic adv_backup_q,
  output logic blk_done_q,
  output logic err_flag_q
);
  import bec_pkg::*;

  // ------------------------------------------------------------
  // phase decode
  // ------------------------------------------------------------
  // one place for every phase compare in the logic; the assertions compare with == directly
  function automatic logic in_ph(input bec_phase_t p, input bec_phase_t w);
    in_ph = (p == w);
  endfunction

  bec_phase_t phase_q; // previous phase, for entry detection
  logic [3:0] units_q; // units ring
  logic [3:0] tens_q; // tens ring, in decades
  logic [7:0] hreg_q; // horizontal check register
  logic [7:0] sreg_q; // spiral check register
  logic [9:0] pulse_cnt_q; // stretches block complete
  logic sclr; // synchronous clear strobe from software
  logic units_wrap; // units at nine and stepping
  logic blk_cmp; // block complete strobe
  logic adv; // sequencer advance strobe
  logic cap; // capture strobe
  logic hmis; // horizontal mismatch
  logic smis; // spiral mismatch
  logic err_set; // common error-setting path
  logic err_clr; // error reset in block number phase
  logic cnt_clr; // counter clear
  logic [7:0] gated; // data let through by the strobe

  assign sclr = reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_CLR_BIT];

  // ------------------------------------------------------------
  // character counter
  // ------------------------------------------------------------
  // entering text or delete, or a backup command, restarts the count
  assign cnt_clr = sclr || backup_cmd ||
    (in_ph(phase, block_text_phase) && !in_ph(phase_q, block_text_phase)) ||
    (in_ph(phase, delete_phase) && !in_ph(phase_q, delete_phase));
  assign units_wrap = char_pulse && (units_q == UNITS_LAST);

  // phase history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= block_number_phase;
    end else begin
      phase_q <= phase;
    end
  end

  // units ring, wraps from nine to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      units_q <= CNT_RST;
    end else if (cnt_clr) begin
      units_q <= CNT_RST;
    end else if (units_wrap) begin
      units_q <= CNT_RST;
    end else if (char_pulse) begin
      units_q <= units_q + 4'h1;
    end
  end

  // tens ring: one decade per units wrap; stops at eighty so a
  // long count cannot fake a second block end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tens_q <= CNT_RST;
    end else if (cnt_clr) begin
      tens_q <= CNT_RST;
    end else if (units_wrap && tens_q != TENS_FULL) begin
      tens_q <= tens_q + 4'h1;
    end
    // otherwise hold
  end

  // ------------------------------------------------------------
  // block end
  // ------------------------------------------------------------
  // armed at seventy outside backup; fires on the step to eighty
  assign blk_cmp = units_wrap && (tens_q == TENS_ARM) &&
    !in_ph(phase, backup_phase) && !cnt_clr;
  assign adv = blk_cmp || ext_adv;

  // pulse stretcher for the visible block complete output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt_q <= 10'h000;
      blk_done_q <= 1'b0;
    end else if (blk_cmp) begin
      pulse_cnt_q <= BLK_PULSE_CYC - 10'h001;
      blk_done_q <= 1'b1;
    end else if (pulse_cnt_q != 10'h000) begin
      pulse_cnt_q <= pulse_cnt_q - 10'h001;
    end else begin
      blk_done_q <= 1'b0;
    end
  end

  // advance strobe out; in spiral phase it also says where to go
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_adv_q <= 1'b0;
      adv_backup_q <= 1'b0;
    end else begin
      seq_adv_q <= adv;
      // follows the flag's next value, so a same-cycle soft clear counts
      adv_backup_q <= adv && in_ph(phase, spiral_check_phase) &&
        (err_set || (err_flag_q && !sclr));
    end
  end

  // ------------------------------------------------------------
  // check registers
  // ------------------------------------------------------------
  assign cap = dly_sample1 && (in_ph(phase, horizontal_check_phase) ||
    in_ph(phase, spiral_check_phase));

  // eight inhibit gates, open only during the strobe
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gate
      assign gated[gi] = data_bits[gi] && cap;
    end
  endgenerate

  // horizontal register: software loads the local value, ones set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hreg_q <= CHK_RST;
    end else if (sclr) begin
      hreg_q <= CHK_RST;
    end else if (reg_wr && reg_addr == OFS_HLOC) begin
      hreg_q <= reg_wdata[7:0];
    end else if (in_ph(phase, horizontal_check_phase)) begin
      hreg_q <= hreg_q | gated;
    end
  end

  // spiral register: untouched in horizontal phase so the local
  // value survives until the second check character arrives
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sreg_q <= CHK_RST;
    end else if (sclr) begin
      sreg_q <= CHK_RST;
    end else if (reg_wr && reg_addr == OFS_SLOC) begin
      sreg_q <= reg_wdata[7:0];
    end else if (in_ph(phase, spiral_check_phase)) begin
      sreg_q <= sreg_q | gated;
    end
  end

  assign hmis = |(~hreg_q);
  assign smis = |(~sreg_q);

  // ------------------------------------------------------------
  // error flag
  // ------------------------------------------------------------
  assign err_set =
    (adv && in_ph(phase, end_of_block_phase) && !eob_valid) ||
    (adv && in_ph(phase, block_number_phase)) ||
    (dly_clk2 && in_ph(phase, horizontal_check_phase) && hmis &&
      !bn_low_seen) ||
    (dly_clk2 && in_ph(phase, spiral_check_phase) && smis) ||
    incomplete_blk;
  assign err_clr = dly_clk2 && in_ph(phase, block_number_phase) &&
    !bn_high;

  // set beats clear, so no event is lost in a clearing cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      err_flag_q <= ERR_RST;
    end else if (err_set) begin
      err_flag_q <= 1'b1;
    end else if (sclr || err_clr) begin
      err_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  // data valid only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= '0;
      unique case (reg_addr)
        OFS_HLOC: reg_rdata_q[7:0] <= hreg_q;
        OFS_SLOC: reg_rdata_q[7:0] <= sreg_q;
        OFS_STAT: begin
          reg_rdata_q[STAT_ERR_BIT] <= err_flag_q;
          reg_rdata_q[STAT_HMIS_BIT] <= hmis;
          reg_rdata_q[STAT_SMIS_BIT] <= smis;
          reg_rdata_q[STAT_UNITS_LSB+:4] <= units_q;
          reg_rdata_q[STAT_TENS_LSB+:4] <= tens_q;
          reg_rdata_q[STAT_HREG_LSB+:8] <= hreg_q;
          reg_rdata_q[STAT_SREG_LSB+:8] <= sreg_q;
        end
        default: reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // helper: cycles blk_done_q has stood since its last start; a
  // retrigger restarts it, just as it restarts the stretcher
  logic [9:0] done_run_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      done_run_q <= 10'h000;
    end else if (blk_cmp) begin
      done_run_q <= 10'h000;
    end else if (blk_done_q) begin
      done_run_q <= done_run_q + 10'h001;
    end else begin
      done_run_q <= 10'h000;
    end
  end

  // counter: one decade per units wrap, nothing in between
  tens_step_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    units_wrap && !cnt_clr && tens_q < TENS_FULL
    |=> tens_q == $past(tens_q) + 4'h1)
    else $error("tens did not step on units wrap");
  tens_hold_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !units_wrap && !cnt_clr |=> $stable(tens_q))
    else $error("tens moved without units wrap");
  count_clear_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    backup_cmd || sclr |=> units_q == CNT_RST && tens_q == CNT_RST)
    else $error("counter not cleared");

  // block end: armed at seventy only; the short repetition catches
  // a stuck stretcher early, the helper count checks the full width
  block_arm_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    blk_cmp |-> tens_q == TENS_ARM && phase != backup_phase)
    else $error("block complete outside seventy");
  block_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    blk_cmp |=> blk_done_q [*8])
    else $error("block complete pulse too short");
  pulse_len_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(blk_done_q) |-> done_run_q == BLK_PULSE_CYC)
    else $error("block complete pulse width wrong");
  adv_out_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    blk_cmp |=> seq_adv_q)
    else $error("no advance after block complete");
  spiral_adv_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    adv && phase == spiral_check_phase |=> adv_backup_q == err_flag_q)
    else $error("spiral advance target wrong");

  // check registers: strobe gating and per-phase loading
  cap_block_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !cap && !reg_wr |=> $stable(hreg_q) && $stable(sreg_q))
    else $error("check register changed without strobe");
  horiz_set_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cap && phase == horizontal_check_phase && !reg_wr
    |=> (hreg_q & $past(data_bits)) == $past(data_bits))
    else $error("horizontal bit not set by data");
  spiral_keep_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    phase == horizontal_check_phase && !reg_wr |=> $stable(sreg_q))
    else $error("spiral register disturbed");
  spiral_set_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cap && phase == spiral_check_phase && !reg_wr
    |=> (sreg_q & $past(data_bits)) == $past(data_bits))
    else $error("spiral bit not set by data");

  // error flag: every setting source, the clears, and the blocks;
  // set beats clear, so these hold even when both fall together
  eob_error_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    adv && phase == end_of_block_phase && !eob_valid |=> err_flag_q)
    else $error("missing end character not recorded");
  eob_good_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    phase == end_of_block_phase && eob_valid && !incomplete_blk && !sclr
    |=> err_flag_q == $past(err_flag_q))
    else $error("valid end character changed flag");
  bn_set_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    adv && phase == block_number_phase |=> err_flag_q)
    else $error("number phase advance did not set flag");
  bn_clear_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    err_clr && !err_set |=> !err_flag_q)
    else $error("flag not cleared by delayed clock");
  horiz_err_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    dly_clk2 && phase == horizontal_check_phase && hmis && !bn_low_seen
    |=> err_flag_q)
    else $error("horizontal mismatch not recorded");
  horiz_low_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    phase == horizontal_check_phase && bn_low_seen && !incomplete_blk &&
    !sclr |=> $stable(err_flag_q))
    else $error("horizontal error set after number low");
  spiral_err_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    dly_clk2 && phase == spiral_check_phase && (sreg_q != 8'hff)
    |=> err_flag_q)
    else $error("spiral mismatch not recorded");
  incomplete_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    incomplete_blk |=> err_flag_q)
    else $error("short block not recorded");
  soft_clear_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sclr && !err_set |=> !err_flag_q && hreg_q == CHK_RST)
    else $error("soft clear ineffective");
endmodule
`default_nettype wire

// >>> tb/bec_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// mode sequencer stand-in
// ------------------------------------------------------------
module bec_seq_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic seq_adv_q,
  input wire logic adv_backup_q,
  input wire logic set_en, // bench pins a phase
  input wire bec_pkg::bec_phase_t set_phase,
  output var bec_pkg::bec_phase_t phase
);
  import bec_pkg::*;
  // steps on each advance pulse in number, text, end and check phases; the bench override wins so that a
  // test can start from any phase without walking the whole cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase <= block_number_phase;
    end else if (set_en) begin
      phase <= set_phase;
    end else if (seq_adv_q) begin
      case (phase)
        block_number_phase: phase <= block_text_phase;
        block_text_phase: phase <= end_of_block_phase;
        end_of_block_phase: phase <= horizontal_check_phase;
        horizontal_check_phase: phase <= spiral_check_phase;
        spiral_check_phase: begin
          phase <= adv_backup_q ? backup_phase : block_number_phase;
        end
        // backup, delete and other phases hold; only the bench override moves them
        default: phase <= phase;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bec_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic eob_valid = 1'b0, bn_high = 1'b0, bn_low_seen = 1'b0;
  logic sen = 1'b0, rd_d = 1'b0;
  logic seq_adv_q, adv_backup_q, blk_done_q, err_flag_q;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_q;
  logic [7:0] data_bits = 8'h00;
  logic [7:0] r;
  logic [5:0] pv = 6'h00; // char, adv, sample1, clk2, short, backup
  logic [63:0] q[$]; // pending reads: expected data over mask
  bec_phase_t phase;
  bec_phase_t sph = block_number_phase;
  int failures = 0, compares = 0, n;

  bec_block_end_check dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .phase(phase),
    .char_pulse(pv[0]), .ext_adv(pv[1]), .eob_valid(eob_valid),
    .bn_high(bn_high), .bn_low_seen(bn_low_seen), .dly_sample1(pv[2]),
    .dly_clk2(pv[3]), .data_bits(data_bits), .incomplete_blk(pv[4]),
    .backup_cmd(pv[5]), .seq_adv_q(seq_adv_q), .adv_backup_q(adv_backup_q),
    .blk_done_q(blk_done_q), .err_flag_q(err_flag_q));
  bec_seq_model seq_u (.clk_sys(clk_sys), .resetn(resetn),
    .seq_adv_q(seq_adv_q), .adv_backup_q(adv_backup_q), .set_en(sen),
    .set_phase(sph), .phase(phase));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // the note goes in before the strobe, so the monitor always finds it
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
    @(posedge clk_sys);
    q.push_back({e & m, m});
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // one-cycle pulses; returns just after the edge that sampled them
  task automatic pul(input logic [5:0] m);
    @(posedge clk_sys);
    pv <= m;
    @(posedge clk_sys);
    pv <= 6'h00;
    #1;
  endtask
  task automatic setph(input bec_phase_t p);
    @(posedge clk_sys);
    sen <= 1'b1;
    sph <= p;
    @(posedge clk_sys);
    sen <= 1'b0;
  endtask
  task automatic ce(input logic e);
    chk("err_flag", {31'h0, err_flag_q}, {31'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, read monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d && q.size() > 0) begin
      chk("read", reg_rdata_q & q[0][31:0], q[0][63:32]);
      void'(q.pop_front());
    end
  end
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hbf460c79));
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_STAT, 32'h0, 32'hffffff01);
    r = 8'($urandom);
    wr(OFS_HLOC, {24'h0, r});
    rd(OFS_HLOC, {24'h0, r}, 32'hff);
    rd(4'h2, 32'h0, 32'hffffffff);
    $display("test regs done");
    // full block: 79 leaves tens at seventy, the 80th completes it
    setph(block_text_phase);
    repeat (79) pul(6'h01);
    rd(OFS_STAT, 32'h7900, 32'hff00);
    pul(6'h01);
    chk("adv", {31'h0, seq_adv_q}, 32'h1);
    n = 0;
    while (blk_done_q === 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("done_len", n, 32'd500);
    chk("phase", {29'h0, phase}, {29'h0, end_of_block_phase});
    rd(OFS_STAT, 32'h8000, 32'hff00);
    $display("test count done");
    eob_valid <= 1'b1;
    pul(6'h02);
    ce(1'b0);
    setph(end_of_block_phase);
    eob_valid <= 1'b0;
    pul(6'h02);
    ce(1'b1);
    $display("test end done");
    wr(OFS_CTRL, 32'h1);
    setph(block_number_phase);
    pul(6'h02);
    ce(1'b1);
    setph(block_number_phase);
    bn_high <= 1'b1;
    pul(6'h08);
    ce(1'b1);
    bn_high <= 1'b0;
    pul(6'h08);
    ce(1'b0);
    $display("test number done");
    // all ones sit on the data lines without a strobe first
    wr(OFS_CTRL, 32'h1);
    setph(horizontal_check_phase);
    data_bits <= 8'hff;
    repeat (3) @(posedge clk_sys);
    r = 8'($urandom) & 8'hfe;
    data_bits <= r;
    pul(6'h04);
    rd(OFS_STAT, {8'h00, r, 16'h0}, 32'hffff0000);
    bn_low_seen <= 1'b1;
    pul(6'h08);
    ce(1'b0);
    bn_low_seen <= 1'b0;
    pul(6'h08);
    ce(1'b1);
    $display("test horizontal done");
    wr(OFS_CTRL, 32'h1);
    setph(spiral_check_phase);
    data_bits <= 8'hff;
    pul(6'h04);
    rd(OFS_STAT, 32'hff000000, 32'hff000004);
    pul(6'h08);
    ce(1'b0);
    pul(6'h02);
    chk("backup", {31'h0, adv_backup_q}, 32'h0);
    @(posedge clk_sys);
    #1;
    chk("phase", {29'h0, phase}, {29'h0, block_number_phase});
    wr(OFS_CTRL, 32'h1);
    setph(spiral_check_phase);
    data_bits <= r;
    pul(6'h04);
    pul(6'h08);
    ce(1'b1);
    pul(6'h02);
    chk("backup", {31'h0, adv_backup_q}, 32'h1);
    @(posedge clk_sys);
    #1;
    chk("phase", {29'h0, phase}, {29'h0, backup_phase});
    $display("test spiral done");
    // in backup the count runs but must not complete a block
    wr(OFS_CTRL, 32'h1);
    repeat (80) pul(6'h01);
    chk("done", {31'h0, blk_done_q}, 32'h0);
    pul(6'h20);
    rd(OFS_STAT, 32'h0, 32'hff00);
    // entry into delete or text restarts a partial count
    repeat (5) pul(6'h01);
    setph(delete_phase);
    rd(OFS_STAT, 32'h0, 32'hff00);
    repeat (3) pul(6'h01);
    setph(block_text_phase);
    rd(OFS_STAT, 32'h0, 32'hff00);
    pul(6'h10);
    ce(1'b1);
    $display("test backup done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
